// [design/bcp_core.sv]
`timescale 1ns/1ps
`include "bcp_map.svh"
// Notes on behaviour
// - Hall reads high above rising threshold
// - Hall reads low below falling threshold
// - Six Hall patterns select two switches
// - PWM from speed command versus sawtooth
// - Only low-side switches are chopped
// - Current limit turns off low sides
// - Current limit released each PWM period
// - Over-current trip turns all off
// - Resume after trip recovery time
// - Undervoltage off until release level
// - Thermal off until release temperature
// - Stop band: low sides off only
// - Below shutdown: all six off
// - Unchanged triple pulse declares lock
// - Resume after lock recovery time
// - Lock times scale with capacitor
// - Lock detection suppressed by listed conditions
// - Hall supply on above shutdown
// - Hall supply cut below shutdown
// - Supply cut: Hall and rotation low
module bcp_core
  import bcp_pkg::*;
#(
  parameter int CLK_MHZ = `BCP_CLK_MHZ,
  parameter int CAP_PF  = 1000,
  parameter int TRS_CYC    = `BCP_TRS_US * CLK_MHZ,
  parameter int LOCK_DETECT_TIME_CYC  = (`BCP_LOCK_DETECT_TIME_US * CLK_MHZ / `BCP_REF_PF) * CAP_PF,
  parameter int LOCK_RECOVERY_TIME_CYC = (`BCP_LOCK_RECOVERY_TIME_US * CLK_MHZ / `BCP_REF_PF) * CAP_PF
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  hall_above_rise,
  input  wire logic [2:0]  hall_below_fall,
  input  wire logic        shunt_over_limit,
  input  wire logic        shunt_over_trip,
  output logic      [2:0]  high_side_on,
  output logic      [2:0]  low_side_on,
  output logic             triple_pulse_rotation_output,
  output logic             single_pulse_rotation_output,
  output logic             hall_supply_output,
  output logic             pwm_clock_node,
  output logic      [7:0]  sawtooth_node
);
  localparam logic [31:0] TRS_W    = 32'(TRS_CYC);
  localparam logic [31:0] LOCK_DETECT_TIME_W  = 32'(LOCK_DETECT_TIME_CYC);
  localparam logic [31:0] LOCK_RECOVERY_TIME_W = 32'(LOCK_RECOVERY_TIME_CYC);

  logic [31:0]  ctrl_reg;
  logic [3:0]   comp_reg;
  logic [7:0]   speed_reg;
  logic         ack_reg;
  logic [31:0]  rdat_reg;
  logic [2:0]   hall;
  logic [15:0]  pwm_cnt_reg;
  logic [7:0]   saw_reg;
  logic         pwm_on;
  logic         cl_reg;
  logic         oc_reg;
  logic [31:0]  oc_cnt_reg;
  logic         uv_reg;
  logic         ot_reg;
  bcp_lock_st_t lock_reg;
  logic [31:0]  lock_cnt_reg;
  logic         tp_prev_reg;
  logic [2:0]   hi_next;
  logic [2:0]   lo_next;
  logic [2:0]   hi_reg;
  logic [2:0]   lo_reg;
  logic         tp_next;
  logic         lock_arm;
  logic         stop_band;
  logic         below_off;
  logic         all_off;
  logic         sel_hit;
  logic [8:0]   saw_sum;

  // -------------------------------------------------------------------
  // Wishbone slave: ack one cycle after strobe, then drop
  // -------------------------------------------------------------------
  assign sel_hit  = wb_cyc_i && wb_stb_i && !ack_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else if (ce) begin
      ack_reg <= sel_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg  <= `BCP_CTRL_RESET;
      comp_reg  <= 4'h0;
      speed_reg <= 8'h00;
    end else if (ce && wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        `BCP_CTRL_OFS:  ctrl_reg  <= {31'h0000_0000, wb_dat_i[0]};
        `BCP_COMP_OFS:  comp_reg  <= wb_dat_i[3:0];
        `BCP_SPEED_OFS: speed_reg <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdat_reg <= 32'h0000_0000;
    end else if (ce && sel_hit) begin
      unique case (wb_adr_i)
        `BCP_CTRL_OFS:  rdat_reg <= ctrl_reg;
        `BCP_COMP_OFS:  rdat_reg <= {28'h000_0000, comp_reg};
        `BCP_STAT_OFS:  rdat_reg <= {19'h0_0000, lock_reg, ot_reg, uv_reg, oc_reg,
                                     cl_reg, pwm_on, hall_supply_output, hall,
                                     triple_pulse_rotation_output,
                                     single_pulse_rotation_output};
        `BCP_LOCKP_OFS: rdat_reg <= lock_cnt_reg;
        `BCP_SPEED_OFS: rdat_reg <= {24'h00_0000, speed_reg};
        default:        rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // -------------------------------------------------------------------
  // Speed command bands and Hall supply
  // -------------------------------------------------------------------
  assign below_off = speed_reg < `BCP_SHUTDOWN_CODE;
  assign stop_band = !below_off && speed_reg < `BCP_SAWLOW_CODE;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hall_supply_output <= 1'b0;
    end else if (ce) begin
      hall_supply_output <= !below_off;
    end
  end

  bcp_hall_dec u_hall (
    .clk        (clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .supply_on  (hall_supply_output),
    .above_rise (hall_above_rise),
    .below_fall (hall_below_fall),
    .hall_lvl   (hall)
  );

  // -------------------------------------------------------------------
  // Internal PWM clock and sawtooth
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pwm_cnt_reg <= 16'h0000;
    end else if (ce) begin
      pwm_cnt_reg <= (pwm_cnt_reg == `BCP_PWM_DIV - 16'h0001) ? 16'h0000
                                                              : pwm_cnt_reg + 16'h0001;
    end
  end

  // Sawtooth rises from saw low; codes above the top are clamped
  assign saw_sum = 9'(`BCP_SAWLOW_CODE)
                   + 9'(32'(pwm_cnt_reg) * 32'(`BCP_SAWSPAN_CODE) / 32'(`BCP_PWM_DIV));
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      saw_reg <= `BCP_SAWLOW_CODE;
    end else if (ce) begin
      saw_reg <= saw_sum[8] ? 8'hFF : saw_sum[7:0];
    end
  end

  assign sawtooth_node  = saw_reg;
  assign pwm_clock_node = pwm_cnt_reg < (`BCP_PWM_DIV >> 1);
  assign pwm_on         = speed_reg > saw_reg;

  // -------------------------------------------------------------------
  // Current limit: set by shunt, released at period start
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cl_reg <= 1'b0;
    end else if (ce) begin
      if (shunt_over_limit) begin
        cl_reg <= 1'b1;
      end else if (pwm_cnt_reg == 16'h0000) begin
        cl_reg <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Over-current trip with timed recovery
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      oc_reg     <= 1'b0;
      oc_cnt_reg <= 32'h0000_0000;
    end else if (ce) begin
      if (shunt_over_trip) begin
        oc_reg     <= 1'b1;
        oc_cnt_reg <= 32'h0000_0000;
      end else if (oc_reg) begin
        if (oc_cnt_reg == TRS_W - 32'h0000_0001) begin
          oc_reg <= 1'b0;
        end
        oc_cnt_reg <= oc_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // -------------------------------------------------------------------
  // Undervoltage and thermal hysteresis
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      uv_reg <= 1'b0;
      ot_reg <= 1'b0;
    end else if (ce) begin
      if (comp_reg[`BCP_COMP_UV]) begin
        uv_reg <= 1'b1;
      end else if (comp_reg[`BCP_COMP_UVREL]) begin
        uv_reg <= 1'b0;
      end
      if (comp_reg[`BCP_COMP_OT]) begin
        ot_reg <= 1'b1;
      end else if (comp_reg[`BCP_COMP_OTREL]) begin
        ot_reg <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Motor lock timer
  // -------------------------------------------------------------------
  assign lock_arm = ctrl_reg[`BCP_CTRL_LOCK_EN] && speed_reg > `BCP_LOCKDIS_CODE
                    && !uv_reg && !ot_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lock_reg     <= BCP_LOCK_RUN;
      lock_cnt_reg <= 32'h0000_0000;
      tp_prev_reg  <= 1'b0;
    end else if (ce) begin
      tp_prev_reg <= triple_pulse_rotation_output;
      unique case (lock_reg)
        BCP_LOCK_RUN: begin
          if (!lock_arm || triple_pulse_rotation_output != tp_prev_reg) begin
            lock_cnt_reg <= 32'h0000_0000;
          end else if (lock_cnt_reg == LOCK_DETECT_TIME_W - 32'h0000_0001) begin
            lock_reg     <= BCP_LOCK_TRIP;
            lock_cnt_reg <= 32'h0000_0000;
          end else begin
            lock_cnt_reg <= lock_cnt_reg + 32'h0000_0001;
          end
        end
        BCP_LOCK_TRIP: begin
          if (lock_cnt_reg == LOCK_RECOVERY_TIME_W - 32'h0000_0001) begin
            lock_reg     <= BCP_LOCK_WAIT;
            lock_cnt_reg <= 32'h0000_0000;
          end else begin
            lock_cnt_reg <= lock_cnt_reg + 32'h0000_0001;
          end
        end
        BCP_LOCK_WAIT: begin
          lock_reg <= BCP_LOCK_RUN;
        end
        default: lock_reg <= BCP_LOCK_RUN;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Commutation decode and output gating
  // -------------------------------------------------------------------
  assign all_off = oc_reg || uv_reg || ot_reg || below_off
                   || lock_reg == BCP_LOCK_TRIP;

  always_comb begin
    hi_next = 3'b000;
    lo_next = 3'b000;
    unique case (hall)
      3'b101: begin hi_next = 3'b010; lo_next = 3'b100; end
      3'b100: begin hi_next = 3'b001; lo_next = 3'b100; end
      3'b110: begin hi_next = 3'b001; lo_next = 3'b010; end
      3'b010: begin hi_next = 3'b100; lo_next = 3'b010; end
      3'b011: begin hi_next = 3'b100; lo_next = 3'b001; end
      3'b001: begin hi_next = 3'b010; lo_next = 3'b001; end
      default: ;
    endcase
    tp_next = hall inside {3'b101, 3'b110, 3'b011, 3'b111};
    if (all_off) begin
      hi_next = 3'b000;
      lo_next = 3'b000;
    end else if (stop_band || cl_reg || !pwm_on) begin
      lo_next = 3'b000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hi_reg                       <= 3'b000;
      lo_reg                       <= 3'b000;
      triple_pulse_rotation_output <= 1'b0;
      single_pulse_rotation_output <= 1'b0;
    end else if (ce) begin
      hi_reg                       <= hi_next;
      lo_reg                       <= lo_next;
      triple_pulse_rotation_output <= tp_next;
      single_pulse_rotation_output <= hall[2];
    end
  end

  assign high_side_on = hi_reg;
  assign low_side_on  = lo_reg;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  sequence trip_seen_s;
    ce && shunt_over_trip;
  endsequence

  oc_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    trip_seen_s ##1 ce |=> hi_reg == 3'b000 && lo_reg == 3'b000)
    else $error("Switches on after over-current trip");
  cl_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && cl_reg |=> lo_reg == 3'b000)
    else $error("Low side on during current limit");
  cl_rel_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && pwm_cnt_reg == 16'h0000 && !shunt_over_limit |=> !cl_reg)
    else $error("Current limit not released at period start");
  pair_a: assert property (@(posedge clk) disable iff (!rst_b)
    (hi_reg & lo_reg) == 3'b000)
    else $error("Shoot-through on a phase");
  stop_band_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && stop_band && $stable(speed_reg) |=> lo_reg == 3'b000)
    else $error("Low side on in stop band");
  shutdown_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && below_off ##1 ce && below_off |=> !hall_supply_output && hi_reg == 3'b000)
    else $error("Drive present below shutdown level");
  rot_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !hall_supply_output ##1 ce && !hall_supply_output
    |=> !single_pulse_rotation_output)
    else $error("Rotation output high with Hall supply cut");
  lock_sup_a: assert property (@(posedge clk) disable iff (!rst_b)
    lock_reg == BCP_LOCK_RUN && (uv_reg || ot_reg) |=> lock_reg == BCP_LOCK_RUN)
    else $error("Lock declared while suppressed");
  uv_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && uv_reg && !comp_reg[`BCP_COMP_UVREL] |=> uv_reg)
    else $error("Undervoltage released before release level");
endmodule

// [include/bcp_map.svh]
`ifndef BCP_MAP_SVH
`define BCP_MAP_SVH

// Register byte offsets
`define BCP_CTRL_OFS        8'h00
`define BCP_COMP_OFS        8'h04
`define BCP_STAT_OFS        8'h08
`define BCP_LOCKP_OFS       8'h0C
`define BCP_SPEED_OFS       8'h10

// Control fields
`define BCP_CTRL_LOCK_EN    0
`define BCP_CTRL_RESET      32'h0000_0001

// Comparator register fields (analog front-end flags written by software)
`define BCP_COMP_UV         0
`define BCP_COMP_UVREL      1
`define BCP_COMP_OT         2
`define BCP_COMP_OTREL      3

// Speed command thresholds in 8-bit DAC codes (about 20 mV per code)
`define BCP_SHUTDOWN_CODE   8'h3E
`define BCP_SAWLOW_CODE     8'h69
`define BCP_LOCKDIS_CODE    8'h6E
`define BCP_SAWHIGH_CODE    9'h10E
`define BCP_SAWSPAN_CODE    8'hA5

// Timing
`define BCP_CLK_MHZ         100
`define BCP_TRS_US          1000
`define BCP_LOCK_DETECT_TIME_US        2000
`define BCP_LOCK_RECOVERY_TIME_US       12000
`define BCP_REF_PF          1000
`define BCP_PWM_DIV         16'h1388

`endif

// [include/bcp_pkg.sv]
package bcp_pkg;
  typedef enum logic [1:0] {
    BCP_LOCK_RUN  = 2'b00,
    BCP_LOCK_TRIP = 2'b01,
    BCP_LOCK_WAIT = 2'b11
  } bcp_lock_st_t;
endpackage

// [design/bcp_hall_dec.sv]
`timescale 1ns/1ps
`include "bcp_map.svh"
module bcp_hall_dec (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       supply_on,
  input  wire logic [2:0] above_rise,
  input  wire logic [2:0] below_fall,
  output logic      [2:0] hall_lvl
);
  logic [2:0] lvl_reg;

  // -------------------------------------------------------------------
  // Hysteresis latch per phase
  // -------------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_ph
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        lvl_reg[i] <= 1'b0;
      end else if (ce) begin
        if (!supply_on) begin
          lvl_reg[i] <= 1'b0;
        end else if (above_rise[i]) begin
          lvl_reg[i] <= 1'b1;
        end else if (below_fall[i]) begin
          lvl_reg[i] <= 1'b0;
        end                                    // Hold otherwise
      end
    end
  end

  assign hall_lvl = lvl_reg;

  hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && supply_on && !above_rise[0] && !below_fall[0] |=> $stable(lvl_reg[0]))
    else $error("Hall level changed inside hysteresis band");
endmodule

// [bench/bcp_hall_model.sv]
`timescale 1ns/1ps
module bcp_hall_model (
  input  wire logic       hall_supply_output,
  input  wire logic [2:0] pattern,
  input  wire logic [2:0] mid,
  input  wire logic [2:0] high_side_on,
  input  wire logic [2:0] low_side_on,
  output logic      [2:0] above_rise,
  output logic      [2:0] below_fall,
  output logic            shoot
);
  // ------------------------------
  // Hall comparators
  // ------------------------------
  always_comb begin
    if (!hall_supply_output) begin
      above_rise = 3'h0;
      below_fall = 3'h7;
    end else begin
      above_rise = pattern & ~mid;
      below_fall = ~pattern & ~mid;
    end
  end
  // Bridge leg shorted
  assign shoot = |(high_side_on & low_side_on);
endmodule

// [bench/bldc_commutation_protection_tb.sv]
`timescale 1ns/1ps
module bldc_commutation_protection_tb;
  localparam int TRS  = 20;
  localparam int TON  = 50;
  localparam int TOFF = 100;
  logic        clk, rst_b, ce, cyc, stb, we, ack, lim, trip, shoot;
  logic        tpo, spo, hso, pwmc;
  logic [7:0]  adr, saw, saw_q;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q, lfsr;
  logic [2:0]  pat, mid, rise, fall, hs, ls;
  int          n_mismatch, checked, cyc_n, i, n;

  bcp_core #(.TRS_CYC(TRS), .LOCK_DETECT_TIME_CYC(TON), .LOCK_RECOVERY_TIME_CYC(TOFF)) u_bcp_core (
    .clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(q), .wb_ack_o(ack),
    .hall_above_rise(rise), .hall_below_fall(fall), .shunt_over_limit(lim),
    .shunt_over_trip(trip), .high_side_on(hs), .low_side_on(ls),
    .triple_pulse_rotation_output(tpo), .single_pulse_rotation_output(spo),
    .hall_supply_output(hso), .pwm_clock_node(pwmc), .sawtooth_node(saw));

  bcp_hall_model u_bcp_hall_model (
    .hall_supply_output(hso), .pattern(pat), .mid(mid), .high_side_on(hs),
    .low_side_on(ls), .above_rise(rise), .below_fall(fall), .shoot(shoot));

  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // {triple, single, high[2:0], low[2:0]}
  function automatic logic [7:0] exp_out(input logic [2:0] p);
    case (p)
      3'h5: exp_out = 8'hD4;
      3'h4: exp_out = 8'h4C;
      3'h6: exp_out = 8'hCA;
      3'h2: exp_out = 8'h22;
      3'h3: exp_out = 8'hA1;
      3'h1: exp_out = 8'h11;
      3'h7: exp_out = 8'hC0;
      default: exp_out = 8'h00;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_out(input string nm, input logic [7:0] e, input logic lo_en);
    chk({nm, " hi"}, {27'h0, e[7:3]}, {27'h0, tpo, spo, hs});
    // Clamped top of sawtooth chops even full speed; low side follows last cycle's saw
    if (saw_q !== 8'hFF) chk({nm, " lo"}, {29'h0, e[2:0] & {3{lo_en}}}, {29'h0, ls});
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do @(negedge clk); while (ack !== 1'b1);
    @(posedge clk);
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic setpat(input logic [2:0] p, input logic [2:0] m);
    @(posedge clk);
    pat <= p;
    mid <= m;
    idle(5);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------
  // Clock, timeout, bridge watch
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    saw_q <= saw;
    cyc_n++;
    if (cyc_n == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  always @(negedge clk) begin
    if (shoot === 1'b1) begin
      n_mismatch++;
      $display("MISMATCH shoot expected 0 seen 1");
    end
  end

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {n_mismatch, checked, cyc_n} = '0;
    lfsr = 32'h0000_f081;
    {rst_b, cyc, stb, we, lim, trip} = '0;
    ce = 1'b1;
    {adr, sel, wdat, pat, mid} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("saw", 32'h0000_0069, {24'h0, saw});
    chk("outs", 32'h0000_0001, {22'h0, hso, tpo, spo, hs, ls, pwmc});
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h0000_0001, rdat);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rdat);
    wb(1'b1, 8'h00, 32'h0);
    $display("test reset done");

    lfsr = nxt(lfsr);
    wb(1'b1, 8'h10, {24'h0, lfsr[7:0] % 8'h3E});
    setpat(3'h7, 3'h0);
    chk("shutdown", 32'h0, {23'h0, hso, tpo, spo, hs, ls});
    wb(1'b0, 8'h08, 32'h0);
    chk("stat hall", 32'h0, {28'h0, rdat[5:2]});
    wb(1'b1, 8'h10, 32'h0000_0050);
    setpat(3'h5, 3'h0);
    chk("hall supply", 32'h1, {31'h0, hso});
    chk_out("stop", 8'hD4, 1'b0);
    $display("test speed bands done");

    wb(1'b1, 8'h10, 32'h0000_00FF);
    for (i = 0; i < 24; i++) begin
      lfsr = nxt(lfsr);
      n = (i < 8) ? i : int'(lfsr[2:0]);
      setpat(n[2:0], 3'h0);
      chk_out("drive", exp_out(n[2:0]), 1'b1);
    end
    setpat(3'h5, 3'h0);
    setpat(3'h2, 3'h7);
    chk_out("hold", 8'hD4, 1'b1);
    setpat(3'h2, 3'h0);
    chk_out("follow", 8'h22, 1'b1);
    $display("test commutation done");

    @(posedge clk);
    lim <= 1'b1;
    idle(20);
    chk_out("limit", 8'h22, 1'b0);
    @(posedge clk);
    lim <= 1'b0;
    n = 0;
    while (ls !== 3'h2 && n < 5100) begin
      @(negedge clk);
      n++;
    end
    chk("limit release", 32'h1, 32'(n < 5100));
    @(posedge clk);
    trip <= 1'b1;
    @(posedge clk);
    trip <= 1'b0;
    idle(TRS - 3);
    chk("trip hold", 32'h0, {26'h0, hs, ls});
    idle(8);
    chk_out("trip resume", 8'h22, 1'b1);
    $display("test current done");

    for (i = 0; i < 2; i++) begin
      wb(1'b1, 8'h04, 32'h1 << (2 * i));
      idle(4);
      chk("prot trip", 32'h0, {26'h0, hs, ls});
      wb(1'b1, 8'h04, 32'h0);
      idle(4);
      chk("prot between", 32'h0, {26'h0, hs, ls});
      wb(1'b1, 8'h04, 32'h2 << (2 * i));
      idle(4);
      chk_out("prot release", 8'h22, 1'b1);
      wb(1'b1, 8'h04, 32'h0);
    end
    $display("test supply and thermal done");

    wb(1'b1, 8'h10, 32'h0000_006E);
    wb(1'b1, 8'h00, 32'h0000_0001);
    idle(TON * 2);
    chk("no lock", 32'h4, {29'h0, hs});
    wb(1'b1, 8'h10, 32'h0000_00FF);
    @(posedge clk);
    pat <= 3'h3;
    n = 0;
    while (hs !== 3'h0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("lock time", 32'h1, 32'(n >= TON && n <= TON + 8));
    n = 0;
    while (hs === 3'h0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("lock recovery", 32'h1, 32'(n >= TOFF - 4 && n <= TOFF + 8));
    $display("test lock done");
    print_verdict();
  end
endmodule
